/* File: core/signal_word_pack_unpack.sv */
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
module signal_word_pack_unpack (
	// clock and resets
	input wire logic pclk,
	input wire logic presetn,
	input wire logic store_rst_n,
	// apb slave
	input wire mux_demux_pkg::apb_req_s apb_req,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// signal sources
	input wire logic [1023:0] logic_sources,
	input wire mux_demux_pkg::proc_words_s proc_words,
	// published words
	output logic [15:0] packed_word,
	output logic [15:0] unpacked_bits
);
	typedef enum {ST_RELOAD, ST_RUN} run_state_e;

	run_state_e state;
	logic [5:0] wr_index;
	logic [5:0] rd_index;
	logic [9:0] unpack_sel;
	logic [15:0][9:0] nv_sel;
	logic [15:0][9:0] work_sel;
	logic access;
	logic wr_take;
	logic rd_load;
	logic bad;
	logic [31:0] next_rdata;
	logic [15:0] next_packed;
	logic [15:0] next_unpacked;
	logic [3:0] wr_entry;
	logic [3:0] rd_entry;
	logic sel_wr;
	logic store_wr;
	logic work_all;
	logic wr_index_we;
	logic rd_index_we;
	logic unpack_sel_we;
	logic restart_we;

	// persistent half of the index space, group index 0 included
	function automatic logic in_store(input logic [5:0] idx);
		return idx <= mux_demux_pkg::IDX_LAST_NV;
	endfunction : in_store

	// unpacker outputs offered back as packing sources
	function automatic logic is_unpack_code(input logic [9:0] code);
		return code >= mux_demux_pkg::CODE_UNPACK_FIRST
			&& code <= mux_demux_pkg::CODE_UNPACK_LAST;
	endfunction : is_unpack_code

	// one wait state: read data is captured on the same edge that raises pready
	assign access = apb_req.psel && apb_req.penable;
	assign rd_load = access && !pready;
	assign wr_take = access && pready && apb_req.pwrite && !pslverr;
	assign sel_wr = wr_take && apb_req.paddr == mux_demux_pkg::ADDR_SEL_DATA;
	assign store_wr = sel_wr && in_store(wr_index);
	assign work_all = wr_index == mux_demux_pkg::IDX_ALL_NV
		|| wr_index == mux_demux_pkg::IDX_ALL_RAM;
	assign wr_entry = mux_demux_pkg::entry_of(wr_index);
	assign rd_entry = mux_demux_pkg::entry_of(rd_index);

	// one write strobe per register, qualified by the completing edge
	assign wr_index_we = wr_take && apb_req.paddr == mux_demux_pkg::ADDR_WR_INDEX;
	assign rd_index_we = wr_take && apb_req.paddr == mux_demux_pkg::ADDR_RD_INDEX;
	assign unpack_sel_we = wr_take && apb_req.paddr == mux_demux_pkg::ADDR_UNPACK_SEL;
	// only a one in bit 0 asks for a reload; a zero write is a harmless no-op
	assign restart_we = wr_take && apb_req.paddr == mux_demux_pkg::ADDR_RESTART
		&& apb_req.pwdata[0];

	// pready falls after one cycle, so an access held on cannot complete in two consecutive cycles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= rd_load;
		end
	end

	// address and value check, decided before the completing edge
	always_comb begin
		bad = 1'b0;
		case (apb_req.paddr)
			mux_demux_pkg::ADDR_WR_INDEX, mux_demux_pkg::ADDR_RD_INDEX: begin
				bad = apb_req.pwrite && !mux_demux_pkg::index_ok(apb_req.pwdata);
			end
			mux_demux_pkg::ADDR_SEL_DATA: begin
				bad = apb_req.pwrite && apb_req.pwdata[31:10] != 22'h0;
			end
			mux_demux_pkg::ADDR_UNPACK_SEL: begin
				bad = apb_req.pwrite && !mux_demux_pkg::unpack_code_ok(apb_req.pwdata);
			end
			mux_demux_pkg::ADDR_PACKED, mux_demux_pkg::ADDR_UNPACKED: begin
				bad = apb_req.pwrite;
			end
			mux_demux_pkg::ADDR_RESTART: begin
				bad = 1'b0;
			end
			default: begin
				bad = 1'b1;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= rd_load && bad;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_index <= mux_demux_pkg::IDX_RESET;
		end else if (wr_index_we) begin
			wr_index <= apb_req.pwdata[5:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_index <= mux_demux_pkg::IDX_RESET;
		end else if (rd_index_we) begin
			rd_index <= apb_req.pwdata[5:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			unpack_sel <= mux_demux_pkg::UNPACK_SEL_RESET;
		end else if (unpack_sel_we) begin
			unpack_sel <= apb_req.pwdata[9:0];
		end
	end

	// persistent store sits on its own reset so a restart leaves it intact
	// persistent writes
	always_ff @(posedge pclk or negedge store_rst_n) begin
		if (!store_rst_n) begin
			nv_sel <= {16{mux_demux_pkg::SEL_RESET}};
		end else if (store_wr) begin
			for (int i = 0; i < mux_demux_pkg::NUM_ENTRIES; i++) begin
				if (wr_index == mux_demux_pkg::IDX_ALL_NV || wr_entry == 4'(i)) begin
					nv_sel[i] <= apb_req.pwdata[9:0];
				end
			end
		end
	end

	// restart: reload once after reset release or on a restart write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ST_RELOAD;
		end else begin
			case (state)
				ST_RELOAD: begin
					state <= ST_RUN;
				end
				ST_RUN: begin
					if (restart_we) begin
						state <= ST_RELOAD;
					end
				end
				default: begin
					state <= ST_RELOAD;
				end
			endcase
		end
	end

	// a reload outranks a selection write landing in the same cycle
	// working copy reload and volatile writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			work_sel <= {16{mux_demux_pkg::SEL_RESET}};
		end else if (state == ST_RELOAD) begin
			work_sel <= nv_sel;
		end else if (sel_wr) begin
			for (int i = 0; i < mux_demux_pkg::NUM_ENTRIES; i++) begin
				if (work_all || wr_entry == 4'(i)) begin
					work_sel[i] <= apb_req.pwdata[9:0];
				end
			end
		end
	end

	always_comb begin
		next_packed = mux_demux_pkg::WORD_ZERO;
		for (int i = 0; i < mux_demux_pkg::NUM_ENTRIES; i++) begin
			if (work_sel[i] == mux_demux_pkg::CODE_OFF) begin
				next_packed[i] = 1'b0;
			end else if (is_unpack_code(work_sel[i])) begin
				next_packed[i] = unpacked_bits[4'(work_sel[i] - mux_demux_pkg::CODE_UNPACK_FIRST)];
			end else begin
				next_packed[i] = logic_sources[work_sel[i]];
			end
		end
	end

	// registered so feeding the packed word back through the unpacker forms no loop
	// publish packed word
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			packed_word <= mux_demux_pkg::WORD_ZERO;
		end else begin
			packed_word <= next_packed;
		end
	end

	always_comb begin
		next_unpacked = mux_demux_pkg::WORD_ZERO;
		if (unpack_sel >= mux_demux_pkg::CODE_RX_FIRST
			&& unpack_sel <= mux_demux_pkg::CODE_RX_LAST) begin
			next_unpacked = proc_words.rx_pdo[5'(unpack_sel - mux_demux_pkg::CODE_RX_FIRST)];
		end else if (unpack_sel >= mux_demux_pkg::CODE_FB_FIRST
			&& unpack_sel <= mux_demux_pkg::CODE_FB_LAST) begin
			next_unpacked = proc_words.fieldbus_output_word[
				2'(unpack_sel - mux_demux_pkg::CODE_FB_FIRST)];
		end else begin
			case (unpack_sel)
				mux_demux_pkg::CODE_REMOTE_CTRL: begin
					next_unpacked = proc_words.remote_ctrl;
				end
				mux_demux_pkg::CODE_REMOTE_STATE: begin
					next_unpacked = proc_words.remote_state;
				end
				mux_demux_pkg::CODE_CTRL_STATUS: begin
					next_unpacked = proc_words.controller_status;
				end
				mux_demux_pkg::CODE_PACKED: begin
					next_unpacked = packed_word;
				end
				default: begin
					// refused codes never land here; zero keeps the output defined
					next_unpacked = mux_demux_pkg::WORD_ZERO;
				end
			endcase
		end
	end

	// bit k is source code 910+k
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			unpacked_bits <= mux_demux_pkg::WORD_ZERO;
		end else begin
			unpacked_bits <= next_unpacked;
		end
	end

	// readback picks persistent or working copy by index
	always_comb begin
		next_rdata = mux_demux_pkg::DATA_ZERO;
		case (apb_req.paddr)
			mux_demux_pkg::ADDR_WR_INDEX: begin
				next_rdata = {26'h0, wr_index};
			end
			mux_demux_pkg::ADDR_RD_INDEX: begin
				next_rdata = {26'h0, rd_index};
			end
			mux_demux_pkg::ADDR_SEL_DATA: begin
				// group indices 0 and 17 show entry 0 of their copy
				if (in_store(rd_index)) begin
					next_rdata = {22'h0, nv_sel[rd_entry]};
				end else begin
					next_rdata = {22'h0, work_sel[rd_entry]};
				end
			end
			mux_demux_pkg::ADDR_UNPACK_SEL: begin
				next_rdata = {22'h0, unpack_sel};
			end
			mux_demux_pkg::ADDR_PACKED: begin
				next_rdata = {16'h0, packed_word};
			end
			mux_demux_pkg::ADDR_UNPACKED: begin
				next_rdata = {16'h0, unpacked_bits};
			end
			mux_demux_pkg::ADDR_RESTART: begin
				next_rdata = {31'h0, state == ST_RELOAD};
			end
			default: begin
				next_rdata = mux_demux_pkg::DATA_ZERO;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= mux_demux_pkg::DATA_ZERO;
		end else if (rd_load) begin
			prdata <= (apb_req.pwrite || bad) ? mux_demux_pkg::DATA_ZERO : next_rdata;
		end
	end
endmodule : signal_word_pack_unpack

/* File: core/mux_demux_pkg.sv */
// What this block does
// - Sixteen packing entries each pick their own logic-signal source and together form one 16-bit word.
// - The packed word is published as source code 927 for use as a transmit or fieldbus input word.
// - The write index takes 0 to 33: 0 all persistent, 1-16 one persistent, 17 all working, 18-33 one working.
// - A write with index 0 updates every entry in both the persistent store and the working copy.
// - Selections written through the persistent range survive a power cycle.
// - Volatile-range writes touch only the working copy, which is reloaded from the store at restart.
// - A separate read index, range 0 to 33 and default 1, picks the entry shown on readback.
// - The unpack select takes zero 9, received words 704-727, remote words 740/741, bus words 754-757, status 900 or 927.
// - Each bit of the selected unpack word is its own signal, bit 0 as code 910 up to bit 15 as code 925.
// - Assigning a selection through index 0 copies it to all sixteen packing entries.
package mux_demux_pkg;
	localparam int NUM_ENTRIES = 16;
	localparam int WORD_W = 16;
	localparam int CODE_W = 10;
	localparam int INDEX_W = 6;
	localparam int ADDR_W = 8;

	// register byte offsets
	localparam logic [7:0] ADDR_WR_INDEX = 8'h00;
	localparam logic [7:0] ADDR_RD_INDEX = 8'h04;
	localparam logic [7:0] ADDR_SEL_DATA = 8'h08;
	localparam logic [7:0] ADDR_UNPACK_SEL = 8'h0C;
	localparam logic [7:0] ADDR_PACKED = 8'h10;
	localparam logic [7:0] ADDR_UNPACKED = 8'h14;
	localparam logic [7:0] ADDR_RESTART = 8'h18;

	// index selector values
	localparam logic [5:0] IDX_ALL_NV = 6'h00;
	localparam logic [5:0] IDX_LAST_NV = 6'h10;
	localparam logic [5:0] IDX_ALL_RAM = 6'h11;
	localparam logic [5:0] IDX_FIRST_RAM = 6'h12;
	localparam logic [5:0] IDX_MAX = 6'h21;
	localparam logic [5:0] IDX_RESET = 6'h01;

	// signal source codes
	localparam logic [9:0] CODE_OFF = 10'h007;
	localparam logic [9:0] CODE_ZERO = 10'h009;
	localparam logic [9:0] CODE_RX_FIRST = 10'h2C0;
	localparam logic [9:0] CODE_RX_LAST = 10'h2D7;
	localparam logic [9:0] CODE_REMOTE_CTRL = 10'h2E4;
	localparam logic [9:0] CODE_REMOTE_STATE = 10'h2E5;
	localparam logic [9:0] CODE_FB_FIRST = 10'h2F2;
	localparam logic [9:0] CODE_FB_LAST = 10'h2F5;
	localparam logic [9:0] CODE_CTRL_STATUS = 10'h384;
	localparam logic [9:0] CODE_UNPACK_FIRST = 10'h38E;
	localparam logic [9:0] CODE_UNPACK_LAST = 10'h39D;
	localparam logic [9:0] CODE_PACKED = 10'h39F;

	localparam logic [9:0] SEL_RESET = CODE_OFF;
	localparam logic [9:0] UNPACK_SEL_RESET = CODE_ZERO;
	localparam logic [15:0] WORD_ZERO = 16'h0000;
	localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

	typedef struct packed {
		logic [23:0][15:0] rx_pdo;
		logic [15:0] remote_ctrl;
		logic [15:0] remote_state;
		logic [3:0][15:0] fieldbus_output_word;
		logic [15:0] controller_status;
	} proc_words_s;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} apb_req_s;

	function automatic logic index_ok(input logic [31:0] value);
		return value <= {26'h0, IDX_MAX};
	endfunction : index_ok

	// entry addressed by a single-entry index; group indices map to entry 0
	function automatic logic [3:0] entry_of(input logic [5:0] idx);
		logic [5:0] e;
		e = 6'h00;
		if (idx >= IDX_FIRST_RAM) begin
			e = idx - IDX_FIRST_RAM;
		end else if (idx != IDX_ALL_NV && idx <= IDX_LAST_NV) begin
			e = idx - 6'h01;
		end
		return e[3:0];
	endfunction : entry_of

	function automatic logic unpack_code_ok(input logic [31:0] c);
		return c == {22'h0, CODE_ZERO}
			|| (c >= {22'h0, CODE_RX_FIRST} && c <= {22'h0, CODE_RX_LAST})
			|| c == {22'h0, CODE_REMOTE_CTRL} || c == {22'h0, CODE_REMOTE_STATE}
			|| (c >= {22'h0, CODE_FB_FIRST} && c <= {22'h0, CODE_FB_LAST})
			|| c == {22'h0, CODE_CTRL_STATUS} || c == {22'h0, CODE_PACKED};
	endfunction : unpack_code_ok
endpackage : mux_demux_pkg

/* File: tb/pdo_peer.sv */
`timescale 1ns/100ps
module pdo_peer (
	// process data words from the far side
	output wire mux_demux_pkg::proc_words_s proc_words,
	// logic signal bank, odd codes high
	output wire logic [1023:0] logic_sources
);
	// every word differs so a wrong route shows up
	for (genvar i = 0; i < 24; i++) begin : g_rx
		assign proc_words.rx_pdo[i] = 16'h8421 ^ 16'(i * 301);
	end
	for (genvar i = 0; i < 4; i++) begin : g_fb
		assign proc_words.fieldbus_output_word[i] = 16'h1E00 + 16'(i * 4369);
	end
	assign proc_words.remote_ctrl = 16'hC3A5;
	assign proc_words.remote_state = 16'h5A3C;
	assign proc_words.controller_status = 16'h0FF0;
	assign logic_sources = {512{2'b10}};
endmodule : pdo_peer

/* File: tb/signal_word_pack_unpack_checker.sv */
`timescale 1ns/100ps
module signal_word_pack_unpack_checker (
	// apb side
	input wire logic pclk,
	input wire logic presetn,
	input wire mux_demux_pkg::apb_req_s apb_req,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// published words
	input wire logic [15:0] packed_word,
	input wire logic [15:0] unpacked_bits
);
	logic done;
	assign done = apb_req.psel && apb_req.penable && pready;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wait_state_a: assert property (apb_req.psel && apb_req.penable && !pready |=> pready)
		else $error("no answer after one wait state");
	pulse_a: assert property (pready |=> !pready)
		else $error("pready held too long");
	wr_range_a:
	assert property (done && apb_req.pwrite && apb_req.paddr == 8'h00
		|-> pslverr == (apb_req.pwdata > 32'h21)) else $error("write index range");
	rd_range_a:
	assert property (done && apb_req.pwrite && apb_req.paddr == 8'h04
		|-> pslverr == (apb_req.pwdata > 32'h21)) else $error("read index range");
	unpack_sel_a:
	assert property (done && apb_req.pwrite && apb_req.paddr == 8'h0C
		|-> pslverr == !(apb_req.pwdata inside {32'h9, [32'h2C0:32'h2D7], 32'h2E4, 32'h2E5,
		[32'h2F2:32'h2F5], 32'h384, 32'h39F})) else $error("unpack code check");
	ro_write_a:
	assert property (done && apb_req.pwrite && apb_req.paddr inside {8'h10, 8'h14}
		|-> pslverr) else $error("read-only word accepted a write");
	packed_read_a:
	assert property (done && !apb_req.pwrite && apb_req.paddr == 8'h10 && $stable(packed_word)
		|-> prdata == {16'h0, packed_word}) else $error("packed readback");
	unpacked_read_a:
	assert property (done && !apb_req.pwrite && apb_req.paddr == 8'h14
		&& $stable(unpacked_bits) |-> prdata == {16'h0, unpacked_bits})
		else $error("unpacked readback");
endmodule : signal_word_pack_unpack_checker

bind signal_word_pack_unpack signal_word_pack_unpack_checker checker_i (.pclk(pclk),
	.presetn(presetn), .apb_req(apb_req), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .packed_word(packed_word), .unpacked_bits(unpacked_bits));

/* File: tb/signal_word_pack_unpack_bench.sv */
`timescale 1ns/100ps
module signal_word_pack_unpack_bench;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic store_rst_n = 1'b0;
	mux_demux_pkg::apb_req_s apb_req = '0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	wire logic [1023:0] logic_sources;
	wire mux_demux_pkg::proc_words_s proc_words;
	logic [15:0] packed_word;
	logic [15:0] unpacked_bits;
	logic [31:0] rd;
	logic er;
	logic [15:0] pack_exp;
	int error_cnt = 0;
	int total_checks = 0;
	logic [9:0] codes [9] = '{10'h009, 10'h2C0, 10'h2D7, 10'h2E4, 10'h2E5, 10'h2F2,
		10'h2F5, 10'h384, 10'h39F};

	initial begin
		forever #50 pclk = ~pclk;
	end

	signal_word_pack_unpack signal_word_pack_unpack_i (.pclk(pclk), .presetn(presetn),
		.store_rst_n(store_rst_n), .apb_req(apb_req), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .logic_sources(logic_sources), .proc_words(proc_words),
		.packed_word(packed_word), .unpacked_bits(unpacked_bits));
	pdo_peer pdo_peer_i (.proc_words(proc_words), .logic_sources(logic_sources));

	function automatic logic [15:0] word_of(input logic [9:0] c);
		case (c) inside
			[10'h2C0:10'h2D7]: return proc_words.rx_pdo[c - 10'h2C0];
			10'h2E4: return proc_words.remote_ctrl;
			10'h2E5: return proc_words.remote_state;
			[10'h2F2:10'h2F5]: return proc_words.fieldbus_output_word[c - 10'h2F2];
			10'h384: return proc_words.controller_status;
			10'h39F: return pack_exp;
			default: return 16'h0;
		endcase
	endfunction : word_of

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] want);
		total_checks++;
		if (seen !== want) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, want, seen);
		end
	endtask : chk

	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : close_out

	// one idle edge first, so psel is never assigned twice in a time step
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		apb_req <= '{1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		apb_req.penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			error_cnt++;
			close_out();
		end
		rd = prdata;
		er = pslverr;
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
	endtask : xfer

	task automatic settle();
		repeat (4) @(posedge pclk);
	endtask : settle

	initial begin
		repeat (10) @(posedge pclk);
		store_rst_n <= 1'b1;
		presetn <= 1'b1;
		xfer(1'b0, 8'h04, 32'h0);
		chk("read index", rd, 32'h1);
		xfer(1'b0, 8'h00, 32'h0);
		chk("write index", rd, 32'h1);
		xfer(1'b0, 8'h0C, 32'h0);
		chk("unpack select", rd, 32'h9);
		$display("test reset values done");
		xfer(1'b1, 8'h00, 32'h0);
		xfer(1'b1, 8'h08, 32'h41);
		settle();
		chk("all entries", packed_word, {16{logic_sources[65]}});
		for (int i = 0; i < 2; i++) begin
			xfer(1'b1, 8'h04, i ? 32'h9 : 32'h11);
			xfer(1'b0, 8'h08, 32'h0);
			chk("both copies", rd, 32'h41);
		end
		for (int n = 1; n <= 16; n++) begin
			xfer(1'b1, 8'h00, 32'(n));
			xfer(1'b1, 8'h08, 32'(64 + n));
			pack_exp[n - 1] = logic_sources[64 + n];
		end
		settle();
		chk("packed port", packed_word, pack_exp);
		xfer(1'b0, 8'h10, 32'h0);
		chk("packed reg", rd, {16'h0, pack_exp});
		$display("test packing done");
		for (int i = 0; i < 2; i++) begin
			xfer(1'b1, 8'h00, 32'h12 - 32'(i));
			xfer(1'b1, 8'h08, 32'h7);
			settle();
			chk("volatile", packed_word, i ? 16'h0 : pack_exp & 16'hFFFE);
			xfer(1'b1, 8'h04, 32'h1);
			xfer(1'b0, 8'h08, 32'h0);
			chk("store kept", rd, 32'h41);
			xfer(1'b1, 8'h18, 32'h1);
			settle();
			chk("reloaded", packed_word, pack_exp);
		end
		// restart by the reset pin drops volatile edits
		xfer(1'b1, 8'h08, 32'h7);
		settle();
		chk("volatile all", packed_word, 16'h0);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		settle();
		chk("pin restart", packed_word, pack_exp);
		xfer(1'b0, 8'h00, 32'h0);
		chk("index after restart", rd, 32'h1);
		xfer(1'b1, 8'h00, 32'h22);
		chk("index 34", er, 1'b1);
		xfer(1'b1, 8'h00, 32'h21);
		chk("index 33", er, 1'b0);
		xfer(1'b1, 8'h04, 32'h22);
		chk("read index 34", er, 1'b1);
		$display("test storage done");
		foreach (codes[i]) begin
			xfer(1'b1, 8'h0C, {22'h0, codes[i]});
			settle();
			chk("unpacked port", unpacked_bits, word_of(codes[i]));
			xfer(1'b0, 8'h14, 32'h0);
			chk("unpacked reg", rd, {16'h0, word_of(codes[i])});
		end
		xfer(1'b1, 8'h0C, 32'h2C0);
		xfer(1'b1, 8'h00, 32'h10);
		xfer(1'b1, 8'h08, 32'h39D);
		settle();
		pack_exp[15] = proc_words.rx_pdo[0][15];
		chk("bit 15 loop", packed_word, pack_exp);
		xfer(1'b1, 8'h0C, 32'h8);
		chk("bad code", er, 1'b1);
		xfer(1'b1, 8'h10, 32'h0);
		chk("ro write", er, 1'b1);
		xfer(1'b0, 8'h1C, 32'h0);
		chk("unmapped err", er, 1'b1);
		chk("unmapped data", rd, 32'h0);
		xfer(1'b1, 8'h08, 32'h400);
		chk("wide select", er, 1'b1);
		xfer(1'b1, 8'h04, 32'h21);
		xfer(1'b0, 8'h08, 32'h0);
		chk("entry 16 working", rd, 32'h39D);
		xfer(1'b0, 8'h18, 32'h0);
		chk("reload idle", rd, 32'h0);
		$display("test unpacking done");
		close_out();
	end
endmodule : signal_word_pack_unpack_bench
